/* logic/probe_pkg.sv */
// Purpose: Shared constants for the test point probe multiplexer
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   Register index times four gives the byte address
package probe_pkg;

  // Bus widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  // Register indices and byte addresses
  localparam logic [7:0]        ANA_IDX   = 8'h50;
  localparam logic [7:0]        DIG_IDX   = 8'h51;
  localparam logic [7:0]        STAT_IDX  = 8'h5f;
  localparam logic [ADDR_W-1:0] ANA_ADDR  = {2'h0, ANA_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] DIG_ADDR  = {2'h0, DIG_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

  // Field layout and reset values
  localparam int unsigned ANA_SEL_W = 5;
  localparam int unsigned DIG_SEL_W = 6;
  localparam int unsigned SCAN_BIT  = 6;
  localparam logic [4:0]  ANA_RST   = 5'h00;
  localparam logic [5:0]  DIG_RST   = 6'h00;

  // Digital selector geometry
  localparam int unsigned DSEL_CODES = 64;
  localparam int unsigned PINS       = 3;

  // Digital selector codes with dedicated sources
  localparam logic [5:0] DSEL_AUX_ADC  = 6'h02;
  localparam logic [5:0] DSEL_LOW_BAT  = 6'h03;
  localparam logic [5:0] DSEL_CLK_OUT  = 6'h05;
  localparam logic [5:0] DSEL_IRQ_ACK  = 6'h0a;
  localparam logic [5:0] DSEL_SER_AUX  = 6'h0c;
  localparam logic [5:0] DSEL_RC_CAL   = 6'h0e;
  localparam logic [5:0] DSEL_OSC_CAL  = 6'h10;
  localparam logic [5:0] DSEL_SYNTH    = 6'h16;
  localparam logic [5:0] DSEL_PHASE    = 6'h1a;
  localparam logic [5:0] DSEL_PWR      = 6'h1d;
  localparam logic [5:0] DSEL_CONV     = 6'h3f;

  // Analog codes without a test point, or with the positive one only
  localparam logic [4:0] ASEL_GAP_LO   = 5'h0b;
  localparam logic [4:0] ASEL_GAP_HI   = 5'h11;
  localparam logic [4:0] ASEL_POS_ONLY = 5'h15;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : probe_pkg

/* logic/reg_req_if.sv */
// Purpose: Register access carrier between bus slave and register file
// Assumes: Decode answers combinationally from the addresses
// Notes:   wr is a one-cycle commit strobe
`timescale 1ns/1ps
interface reg_req_if;
  import probe_pkg::*;
  logic              wr;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [3:0]        wstrb;
  logic              werr;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  logic              rerr;
  modport bus  (output wr, waddr, wdata, wstrb, raddr, input werr, rdata, rerr);
  modport regs (input wr, waddr, wdata, wstrb, raddr, output werr, rdata, rerr);
endinterface : reg_req_if

/* logic/axil_slave.sv */
// Purpose: AXI4-Lite slave front end for the probe registers
// Assumes: One write and one read under way at a time
// Notes:   Address and data are taken in either order
`timescale 1ns/1ps
module axil_slave
  import probe_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  // Write channels
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [ADDR_W-1:0]       i_awaddr,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  input  wire logic [DATA_W-1:0]       i_wdata,
  input  wire logic [3:0]              i_wstrb,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  output logic [1:0]                   o_bresp,
  // Read channels
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  input  wire logic [ADDR_W-1:0]       i_araddr,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  output logic [DATA_W-1:0]            o_rdata,
  output logic [1:0]                   o_rresp,
  // Register side
  reg_req_if.bus                       rq
);
  logic aw_held;
  logic w_held;
  logic commit;

  // Commit once both halves are held and no answer waits
  assign commit    = aw_held && w_held && !o_bvalid;
  assign rq.wr     = commit;
  assign rq.raddr  = i_araddr;

  // Write readies as flops; a slot frees only when the answer is taken
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
    end
    else if (o_bvalid && i_bready)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
    end
    else
    begin
      if (i_awvalid && o_awready)
        o_awready <= 1'b0;
      if (i_wvalid && o_wready)
        o_wready <= 1'b0;
    end
  end

  // Read ready as a flop, low while an answer stands
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_arready <= 1'b1;
    else if (i_arvalid && o_arready)
      o_arready <= 1'b0;
    else if (o_rvalid && i_rready)
      o_arready <= 1'b1;
  end

  // Capture write address
  always_ff @(posedge i_clk)
  begin
    if (i_srst || commit)
      aw_held <= 1'b0;
    else if (i_awvalid && o_awready)
      aw_held <= 1'b1;
    if (i_awvalid && o_awready)
      rq.waddr <= i_awaddr;
  end

  // Capture write data
  always_ff @(posedge i_clk)
  begin
    if (i_srst || commit)
      w_held <= 1'b0;
    else if (i_wvalid && o_wready)
      w_held <= 1'b1;
    if (i_wvalid && o_wready)
    begin
      rq.wdata <= i_wdata;
      rq.wstrb <= i_wstrb;
    end
  end

  // Write response follows the commit
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end
    else if (commit)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= rq.werr ? RESP_SLVERR : RESP_OKAY;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // Read answer one cycle after the address
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rdata  <= rq.rdata;
      o_rresp  <= rq.rerr ? RESP_SLVERR : RESP_OKAY;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end
endmodule : axil_slave

/* logic/sig_select.sv */
// Purpose: Picks one group of pin signals from a flat code table
// Assumes: Table holds CODES groups of WIDTH bits, code 0 lowest
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/1ps
module sig_select #(
  parameter int unsigned CODES = 64,
  parameter int unsigned WIDTH = 3
) (
  // Table and selector
  input  wire logic [CODES*WIDTH-1:0]  i_table,
  input  wire logic [$clog2(CODES)-1:0] i_sel,
  // Chosen group
  output logic [WIDTH-1:0]              o_group
);
  // A table that is not a power of two would leave codes undefined
  if (CODES < 2 || (CODES & (CODES - 1)) != 0 || WIDTH < 1)
  begin : g_bad_size
    $error("sig_select: CODES must be a power of two, WIDTH nonzero");
  end

  // Indexed slice of the table
  assign o_group = i_table[i_sel*WIDTH +: WIDTH];
endmodule : sig_select

/* logic/test_bus_probe_mux.sv */
// Purpose: Routes chosen internal test points to probe and GPIO pins
// Assumes: All internal signals synchronous to i_clk
// Notes:   Pin outputs lag a register write by one cycle
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - Analog select picks one internal node pair for the probe pins
// - Scan bit set makes GPIO pin 0 the scan-shift enable input
// - Digital select drives three chosen signals onto GPIO pins 0 to 2
// - Code 2 shows aux converter enable, ready low, done
// - Code 3 shows low-battery continuous, detector on, raw output
// - Code 5 shows synced divider enable, clock-out enable, synced version
// - Code 10 shows both interrupt acknowledges and latch closed
// - Code 12 shows serial-out aux select, aux signal, irq aux select
// - Code 14 shows RC calibration starts and crystal request
// - Code 16 shows calibration reset low, running, done
// - Code 22 shows synthesizer enable and both settling flags
// - Code 26 shows phase up, down and their exclusive-OR
// - Code 29 shows power-state bits 0 to 2 on pins 0 to 2
// - Code 63 shows converter enable, reference DAC enable, reset
module test_bus_probe_mux
  import probe_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  // AXI4-Lite write
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [ADDR_W-1:0]       i_awaddr,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  input  wire logic [DATA_W-1:0]       i_wdata,
  input  wire logic [3:0]              i_wstrb,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  output logic [1:0]                   o_bresp,
  // AXI4-Lite read
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  input  wire logic [ADDR_W-1:0]       i_araddr,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  output logic [DATA_W-1:0]            o_rdata,
  output logic [1:0]                   o_rresp,
  // Dedicated digital sources, bit 0 goes to pin 0
  input  wire logic [2:0]              i_aux_adc,
  input  wire logic [2:0]              i_low_bat,
  input  wire logic [2:0]              i_clk_out_en,
  input  wire logic [2:0]              i_irq_ack,
  input  wire logic [2:0]              i_ser_aux,
  input  wire logic [2:0]              i_rc_cal,
  input  wire logic [2:0]              i_osc_cal,
  input  wire logic [2:0]              i_synth,
  input  wire logic                    i_pfd_up,
  input  wire logic                    i_pfd_down,
  input  wire logic [2:0]              i_power_state,
  input  wire logic [2:0]              i_conv,
  // Remaining codes, three bits per code
  input  wire logic [DSEL_CODES*PINS-1:0] i_other_sig,
  // GPIO function and normal path
  input  wire logic [PINS-1:0]         i_gpio_test_fn,
  input  wire logic [PINS-1:0]         i_gpio_norm_out,
  input  wire logic [PINS-1:0]         i_gpio_norm_oe_n,
  input  wire logic [PINS-1:0]         i_gpio_in,
  // GPIO pins
  output logic [PINS-1:0]              o_gpio_out,
  output logic [PINS-1:0]              o_gpio_oe_n,
  output logic                         o_scan_shift_enable,
  // Analog probe switch controls
  output logic [ANA_SEL_W-1:0]         o_probe_sel,
  output logic                         o_probe_pos_pin_en,
  output logic                         o_probe_neg_pin_en
);
  reg_req_if rq ();

  logic [ANA_SEL_W-1:0]      ana_sel;
  logic [DIG_SEL_W-1:0]      dig_sel;
  logic                      scan_mode;
  logic [DSEL_CODES*PINS-1:0] src_table;
  logic [PINS-1:0]           picked;
  logic [PINS-1:0]           next_gpio_out;
  logic [PINS-1:0]           next_gpio_oe_n;
  logic                      next_pos_en;
  logic                      next_neg_en;
  logic                      wr_lane0;

  // Bus front end
  axil_slave u_bus (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_awaddr  (i_awaddr),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .o_bresp   (o_bresp),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .i_araddr  (i_araddr),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .rq        (rq)
  );

  // Write decode; the status word is read only
  assign rq.werr = !(rq.waddr == ANA_ADDR || rq.waddr == DIG_ADDR);
  assign wr_lane0 = rq.wr && rq.wstrb[0];

  // Read decode; reserved bits read zero
  always_comb
  begin
    rq.rdata = '0;
    rq.rerr  = 1'b0;
    case (rq.raddr)
      ANA_ADDR:
        rq.rdata[ANA_SEL_W-1:0] = ana_sel;
      DIG_ADDR:
      begin
        rq.rdata[DIG_SEL_W-1:0] = dig_sel;
        rq.rdata[SCAN_BIT]      = scan_mode;
      end
      STAT_ADDR:
        rq.rdata[8:0] = {o_probe_neg_pin_en, o_probe_pos_pin_en,
                         o_scan_shift_enable, o_gpio_oe_n, o_gpio_out};
      default:
        rq.rerr = 1'b1;
    endcase
  end

  // Analog selector register, lane 0 only
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ana_sel <= ANA_RST;
    else if (wr_lane0 && rq.waddr == ANA_ADDR)
      ana_sel <= rq.wdata[ANA_SEL_W-1:0];
  end

  // Digital selector and scan bit, lane 0 only
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      dig_sel   <= DIG_RST;
      scan_mode <= 1'b0;
    end
    else if (wr_lane0 && rq.waddr == DIG_ADDR)
    begin
      dig_sel   <= rq.wdata[DIG_SEL_W-1:0];
      scan_mode <= rq.wdata[SCAN_BIT];
    end
  end

  // Source table: generic codes, then dedicated groups on top
  always_comb
  begin
    src_table = i_other_sig;
    src_table[DSEL_AUX_ADC*PINS +: PINS] = i_aux_adc;
    src_table[DSEL_LOW_BAT*PINS +: PINS] = i_low_bat;
    src_table[DSEL_CLK_OUT*PINS +: PINS] = i_clk_out_en;
    src_table[DSEL_IRQ_ACK*PINS +: PINS] = i_irq_ack;
    src_table[DSEL_SER_AUX*PINS +: PINS] = i_ser_aux;
    src_table[DSEL_RC_CAL*PINS +: PINS] = i_rc_cal;
    src_table[DSEL_OSC_CAL*PINS +: PINS] = i_osc_cal;
    src_table[DSEL_SYNTH*PINS +: PINS] = i_synth;
    src_table[DSEL_PHASE*PINS +: PINS] = {i_pfd_up ^ i_pfd_down, i_pfd_down, i_pfd_up};
    src_table[DSEL_PWR*PINS +: PINS] = i_power_state;
    src_table[DSEL_CONV*PINS +: PINS] = i_conv;
  end

  sig_select #(
    .CODES (DSEL_CODES),
    .WIDTH (PINS)
  ) u_select (
    .i_table (src_table),
    .i_sel   (dig_sel),
    .o_group (picked)
  );

  // Pin drive choice per pin
  always_comb
  begin
    for (int p = 0; p < PINS; p++)
    begin
      if (i_gpio_test_fn[p])
      begin
        next_gpio_out[p]  = picked[p];
        next_gpio_oe_n[p] = 1'b0;
      end
      else
      begin
        next_gpio_out[p]  = i_gpio_norm_out[p];
        next_gpio_oe_n[p] = i_gpio_norm_oe_n[p];
      end
    end
    if (scan_mode)
    begin
      next_gpio_out[0]  = 1'b0;
      next_gpio_oe_n[0] = 1'b1;
    end
  end

  // Registered pin outputs
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_gpio_out  <= '0;
      o_gpio_oe_n <= '1;
    end
    else
    begin
      o_gpio_out  <= next_gpio_out;
      o_gpio_oe_n <= next_gpio_oe_n;
    end
  end

  // Scan enable taken from pin 0
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_scan_shift_enable <= 1'b0;
    else
      o_scan_shift_enable <= scan_mode && i_gpio_in[0];
  end

  always_comb
  begin
    next_pos_en = !(ana_sel == '0 ||
                    (ana_sel >= ASEL_GAP_LO && ana_sel <= ASEL_GAP_HI));
    next_neg_en = next_pos_en && ana_sel != ASEL_POS_ONLY;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_probe_sel        <= ANA_RST;
      o_probe_pos_pin_en <= 1'b0;
      o_probe_neg_pin_en <= 1'b0;
    end
    else
    begin
      o_probe_sel        <= ana_sel;
      o_probe_pos_pin_en <= next_pos_en;
      o_probe_neg_pin_en <= next_neg_en;
    end
  end

  // Checks on pin behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence test_pin1_s(logic [5:0] code);
    dig_sel == code && i_gpio_test_fn[1] && !rq.wr;
  endsequence

  analog_select_a: assert property (
    !rq.wr |=> o_probe_sel == $past(ana_sel))
    else $error("probe select does not follow register");
  scan_release_a: assert property (
    scan_mode && !rq.wr |=> o_gpio_oe_n[0] && o_scan_shift_enable == $past(i_gpio_in[0]))
    else $error("scan mode does not release pin 0");
  digital_pick_a: assert property (
    i_gpio_test_fn[2] |=> o_gpio_out[2] == $past(picked[2]) && !o_gpio_oe_n[2])
    else $error("pin 2 does not carry picked signal");
  aux_adc_a: assert property (
    test_pin1_s(DSEL_AUX_ADC) |=> o_gpio_out[1] == $past(i_aux_adc[1]))
    else $error("code 2 pin 1 wrong");
  irq_ack_a: assert property (
    test_pin1_s(DSEL_IRQ_ACK) |=> o_gpio_out[1] == $past(i_irq_ack[1]))
    else $error("code 10 pin 1 wrong");
  phase_xor_a: assert property (
    dig_sel == DSEL_PHASE && i_gpio_test_fn[2] && !scan_mode
    |=> o_gpio_out[2] == ($past(i_pfd_up) ^ $past(i_pfd_down)))
    else $error("code 26 exclusive-OR wrong");
  power_state_a: assert property (
    test_pin1_s(DSEL_PWR) |=> o_gpio_out[1] == $past(i_power_state[1]))
    else $error("code 29 pin 1 wrong");
  conv_top_a: assert property (
    test_pin1_s(DSEL_CONV) |=> o_gpio_out[1] == $past(i_conv[1]))
    else $error("code 63 pin 1 wrong");

  // Remaining dedicated groups watched on pin 1, then analog, normal path and pin 0 checks
  low_bat_a: assert property (
    test_pin1_s(DSEL_LOW_BAT) |=> o_gpio_out[1] == $past(i_low_bat[1]))
    else $error("code 3 pin 1 wrong");
  clk_out_a: assert property (
    test_pin1_s(DSEL_CLK_OUT) |=> o_gpio_out[1] == $past(i_clk_out_en[1]))
    else $error("code 5 pin 1 wrong");
  ser_aux_a: assert property (
    test_pin1_s(DSEL_SER_AUX) |=> o_gpio_out[1] == $past(i_ser_aux[1]))
    else $error("code 12 pin 1 wrong");
  rc_cal_a: assert property (
    test_pin1_s(DSEL_RC_CAL) |=> o_gpio_out[1] == $past(i_rc_cal[1]))
    else $error("code 14 pin 1 wrong");
  osc_cal_a: assert property (
    test_pin1_s(DSEL_OSC_CAL) |=> o_gpio_out[1] == $past(i_osc_cal[1]))
    else $error("code 16 pin 1 wrong");
  synth_flags_a: assert property (
    test_pin1_s(DSEL_SYNTH) |=> o_gpio_out[1] == $past(i_synth[1]))
    else $error("code 22 pin 1 wrong");
  analog_gap_a: assert property (
    (ana_sel inside {[ASEL_GAP_LO:ASEL_GAP_HI]} && !rq.wr) [*2]
    |=> !o_probe_pos_pin_en && !o_probe_neg_pin_en)
    else $error("reserved analog code connects probe");
  normal_pin_a: assert property (
    !i_gpio_test_fn[1] |=> o_gpio_oe_n[1] == $past(i_gpio_norm_oe_n[1]))
    else $error("normal pin path disturbed");
  pin0_pick_a: assert property (
    i_gpio_test_fn[0] && !scan_mode |=> o_gpio_out[0] == $past(picked[0]) && !o_gpio_oe_n[0])
    else $error("pin 0 does not carry picked signal");
  pos_only_a: assert property (
    ana_sel == ASEL_POS_ONLY |=> o_probe_pos_pin_en && !o_probe_neg_pin_en)
    else $error("code 21 probe switches wrong");
endmodule : test_bus_probe_mux

/* sim/probe_pin_partner.sv */
// Purpose: Test equipment model watching and driving the three GPIO pins
// Assumes: Pin level is the device drive when enabled, else the equipment
// Notes:   Released pins 1 and 2 toggle so a stale level never passes
`timescale 1ns/1ps
module probe_pin_partner
  import probe_pkg::*;
(
  // Clock
  input  wire logic            i_clk,
  // Device pin drive
  input  wire logic [PINS-1:0] i_gpio_out,
  input  wire logic [PINS-1:0] i_gpio_oe_n,
  // Scan-shift enable level offered on pin 0
  input  wire logic            i_scan_level,
  // Resolved pin levels
  output logic      [PINS-1:0] o_gpio_in
);
  import probe_pkg::*;
  logic [PINS-1:0] toggle = 3'h0;

  // Pattern for undriven pins, changes every cycle
  always_ff @(posedge i_clk)
  begin
    toggle <= ~toggle;
  end

  // Wire resolution; pin 0 carries the scan-shift enable when released
  // scan enable drive
  always_comb
  begin
    for (int n = 0; n < PINS; n++)
    begin
      if (!i_gpio_oe_n[n])
        o_gpio_in[n] = i_gpio_out[n];
      else if (n == 0)
        o_gpio_in[n] = i_scan_level;
      else
        o_gpio_in[n] = toggle[n];
    end
  end
endmodule : probe_pin_partner

/* sim/tb.sv */
// Purpose: Self-checking bench for the probe multiplexer
// Assumes: AXI4-Lite master, pins settle a few cycles after a write
// Notes:   Random stimulus from a fixed xorshift seed
`timescale 1ns/1ps
module tb;
  import probe_pkg::*;
  logic i_clk, i_srst, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [2:0] aux_adc, low_bat, clk_out_en, irq_ack, ser_aux, rc_cal, osc_cal, synth;
  logic [2:0] power_state, conv, test_fn, norm_out, norm_oe_n, gpio_in, gpio_out, gpio_oe_n;
  logic pfd_up, pfd_down, scan_level, scan_bit, scan_en, pos_en, neg_en, awready, wready;
  logic bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [4:0] probe_sel;
  logic [DSEL_CODES*PINS-1:0] other_sig;
  logic [31:0] seed = 32'h0001_0438;
  int n_errors = 0;
  int num_checks = 0;

  test_bus_probe_mux dut (.i_clk(i_clk), .i_srst(i_srst), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_aux_adc(aux_adc),
    .i_low_bat(low_bat), .i_clk_out_en(clk_out_en), .i_irq_ack(irq_ack),
    .i_ser_aux(ser_aux), .i_rc_cal(rc_cal), .i_osc_cal(osc_cal), .i_synth(synth),
    .i_pfd_up(pfd_up), .i_pfd_down(pfd_down), .i_power_state(power_state), .i_conv(conv),
    .i_other_sig(other_sig), .i_gpio_test_fn(test_fn), .i_gpio_norm_out(norm_out),
    .i_gpio_norm_oe_n(norm_oe_n), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out),
    .o_gpio_oe_n(gpio_oe_n), .o_scan_shift_enable(scan_en), .o_probe_sel(probe_sel),
    .o_probe_pos_pin_en(pos_en), .o_probe_neg_pin_en(neg_en));

  probe_pin_partner eqp (.i_clk(i_clk), .i_gpio_out(gpio_out), .i_gpio_oe_n(gpio_oe_n),
    .i_scan_level(scan_level), .o_gpio_in(gpio_in));

  // 50 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Xorshift source, seed 66616
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Group each dedicated code should show, bit n on pin n
  function automatic logic [2:0] exp_pick(input logic [5:0] c);
    case (c)
      DSEL_AUX_ADC: return aux_adc;
      DSEL_LOW_BAT: return low_bat;
      DSEL_CLK_OUT: return clk_out_en;
      DSEL_IRQ_ACK: return irq_ack;
      DSEL_SER_AUX: return ser_aux;
      DSEL_RC_CAL:  return rc_cal;
      DSEL_OSC_CAL: return osc_cal;
      DSEL_SYNTH:   return synth;
      DSEL_PHASE:   return {pfd_up ^ pfd_down, pfd_down, pfd_up};
      DSEL_PWR:     return power_state;
      DSEL_CONV:    return conv;
      default:      return other_sig[3*c +: 3];
    endcase
  endfunction : exp_pick

  // Expected {oe_n, out}; scan mode releases pin 0
  function automatic logic [5:0] exp_pins(input logic [5:0] c);
    logic [2:0] p;
    logic [2:0] o;
    logic [2:0] e;
    p = exp_pick(c);
    for (int n = 0; n < 3; n++)
    begin
      if (scan_bit && n == 0)
        {e[n], o[n]} = 2'h2;
      else if (test_fn[n])
        {e[n], o[n]} = {1'b0, p[n]};
      else
        {e[n], o[n]} = {norm_oe_n[n], norm_out[n]};
    end
    return {e, o};
  endfunction : exp_pins

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  // Fresh values on every internal source and the normal pin path
  task automatic rand_src();
    {aux_adc, low_bat, clk_out_en, irq_ack, ser_aux, rc_cal, osc_cal, synth} <= 24'(rnd());
    {power_state, conv, pfd_up, pfd_down, norm_out, norm_oe_n} <= 14'(rnd());
    for (int k = 0; k < 6; k++)
      other_sig[32*k +: 32] <= rnd();
  endtask : rand_src

  // Bus write; address and data offered together, each dropped once taken
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int k;
    @(posedge i_clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    for (k = 0; k < 200; k++)
    begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (k == 200) begin n_errors++; end_of_test(); end
    chk(32'(bresp), 32'(er));
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int k;
    @(posedge i_clk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    for (k = 0; k < 200; k++)
    begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (k == 200) begin n_errors++; end_of_test(); end
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask : axi_read

  initial
  begin
    logic [5:0] c;
    logic [7:0] v;
    {i_srst, awvalid, wvalid, bready, arvalid, rready, scan_level, scan_bit} = 8'h80;
    {awaddr, araddr, wdata, wstrb} = '0;
    {test_fn, norm_out, norm_oe_n, aux_adc, low_bat, clk_out_en, irq_ack} = '0;
    {ser_aux, rc_cal, osc_cal, synth, power_state, conv, pfd_up, pfd_down} = '0;
    other_sig = '0;
    cyc(16);
    i_srst <= 1'b0;
    // Reset values, masking of reserved bits, refused places
    axi_read(ANA_ADDR, 32'h0, RESP_OKAY);
    axi_read(DIG_ADDR, 32'h0, RESP_OKAY);
    axi_write(ANA_ADDR, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_read(ANA_ADDR, 32'h1f, RESP_OKAY);
    axi_write(DIG_ADDR, 32'h0000_00ff, 4'hf, RESP_OKAY);
    axi_write(DIG_ADDR, 32'h0000_0000, 4'he, RESP_OKAY);
    axi_read(DIG_ADDR, 32'h7f, RESP_OKAY);
    axi_write(12'h3f0, 32'h0000_0011, 4'hf, RESP_SLVERR);
    axi_read(12'h3f0, 32'h0, RESP_SLVERR);
    axi_write(STAT_ADDR, 32'h0000_0001, 4'hf, RESP_SLVERR);
    $display("test registers done");
    // Every digital code; pass 0 all pins in test function, pass 1 random
    for (int pass = 0; pass < 2; pass++)
    begin
      for (int i = 0; i < DSEL_CODES; i++)
      begin
        c = 6'(i);
        v = 8'(rnd());
        rand_src();
        test_fn <= (pass == 0) ? 3'h7 : v[2:0];
        scan_bit <= (pass == 1) && v[3];
        scan_level <= v[4];
        axi_write(DIG_ADDR, {24'h0, v[7], (pass == 1) && v[3], c}, 4'hf, RESP_OKAY);
        cyc(4);
        chk(32'({gpio_oe_n, gpio_out}), 32'(exp_pins(c)));
        chk(32'(scan_en), 32'(scan_bit && scan_level));
        rand_src();
        cyc(3);
        chk(32'({gpio_oe_n, gpio_out}), 32'(exp_pins(c)));
      end
    end
    $display("test digital select done");
    // Every analog code, reserved upper bits set at random
    for (int i = 0; i < 32; i++)
    begin
      v = 8'(rnd());
      axi_write(ANA_ADDR, {24'h0, v[7:5], 5'(i)}, 4'hf, RESP_OKAY);
      cyc(3);
      chk(32'(probe_sel), 32'(i));
      chk(32'(pos_en), 32'(!(i == 0 || (i >= 11 && i <= 17))));
      chk(32'(neg_en), 32'(!(i == 0 || (i >= 11 && i <= 17) || i == 21)));
    end
    // Status word: last analog code connects both, pins as last digital code
    axi_read(STAT_ADDR, {23'h0, 2'h3, scan_bit && scan_level, exp_pins(DSEL_CONV)}, RESP_OKAY);
    $display("test analog select done");
    end_of_test();
  end
endmodule : tb
